// ### shared/msgctl_pkg.sv
// Register map, field positions and cost helpers for message controls
package msgctl_pkg;

	// ------------------------------------------------------------------
	// Message kinds and partition encodings
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		skip_intra_check_message,
		integer_search_message,
		fractional_bidir_refine_message,
		distortion_mesh_message
	} msg_kind_t;

	typedef enum logic [1:0] {
		part_16x16,
		part_16x8,
		part_8x16,
		part_8x8
	} partition_type_t;

	// ------------------------------------------------------------------
	// Register word indices (byte offset is four times the index)
	// ------------------------------------------------------------------
	localparam int         NUM_WORDS = 19;
	localparam logic [5:0] W_CTRL    = 6'h00;
	localparam logic [5:0] W_LIMIT   = 6'h01;
	localparam logic [5:0] W_SEARCH  = 6'h02;
	localparam logic [5:0] W_COST    = 6'h03;
	localparam logic [5:0] W_REFINE  = 6'h08;
	localparam logic [5:0] W_THR_LO  = 6'h09;
	localparam logic [5:0] W_THR_HI  = 6'h0A;
	localparam logic [5:0] W_CENTRE  = 6'h0B;
	localparam logic [5:0] W_STATUS  = 6'h13;
	localparam logic [31:0] RESET_VALUE = 32'h00000000;

	// ------------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------------
	localparam int CTRL_LINEAR  = 2;
	localparam int CTRL_EARLY   = 3;
	localparam int LIM_EXT      = 6;
	localparam int SRCH_SKIP    = 0;
	localparam int SRCH_ADAPT   = 1;
	localparam int SRCH_BIMIX   = 2;
	localparam int SRCH_FULLPEL = 5;
	localparam int SRCH_XONLY   = 6;
	localparam int SRCH_XFORM   = 7;
	localparam int SHAPE_LSB    = 8;
	localparam int DIR_LSB      = 16;
	localparam int STAT_HIT     = 5;
	localparam logic [1:0] SHAPE_8X8   = 2'h0;
	localparam logic [1:0] DIR_ILLEGAL = 2'h3;
	localparam logic [1:0] CHROMA_DC    = 2'h0;
	localparam logic [1:0] CHROMA_PLANE = 2'h3;

	// ------------------------------------------------------------------
	// Cost codes: modes 0..9, reference id, chroma, 8 points, early stop
	// ------------------------------------------------------------------
	localparam int NUM_CODES   = 21;
	localparam int NUM_MODES   = 10;
	localparam int REFID_CODE  = 10;
	localparam int CHROMA_CODE = 11;
	localparam int MV_CODE0    = 12;
	localparam int EARLY_CODE  = 20;
	localparam logic [9:0] MODE_WIDE = 10'h31E;

	// Largest decoded value allowed for each cost code
	function automatic logic [13:0] cost_cap(input int i);
		if (i == EARLY_CODE)
			return 14'h3FFF;
		if (i >= MV_CODE0)
			return 14'h03FF;
		if (i < NUM_MODES && !MODE_WIDE[i])
			return 14'h03FF;
		return 14'h0FFF;
	endfunction

	// Writable bits of each word; the rest read as zero
	function automatic logic [31:0] write_mask(input int idx);
		case (idx)
			W_CTRL:   return 32'h0000000F;
			W_LIMIT:  return 32'h0000007F;
			W_SEARCH: return 32'hFF0000E7;
			W_REFINE: return 32'h00FFFF03;
			default:  return 32'hFFFFFFFF;
		endcase
	endfunction

endpackage

// ### shared/cost_if.sv
// Carrier between the control block and its cost decoders
`timescale 1ns/1ps
interface cost_if;
	logic [7:0]  code;
	logic [13:0] cap;
	logic [13:0] value;
	modport user   (output code, output cap, input value);
	modport unpack (input code, input cap, output value);
endinterface

// ### hw/cost_unpack.sv
// Decoder for the two-nibble cost format with saturation
`timescale 1ns/1ps
module cost_unpack (
	cost_if.unpack port
);
	logic [18:0] full;

	// Low nibble is the base, high nibble the shift
	always_comb begin
		full = 19'(port.code[3:0]) << port.code[7:4];
		port.value = (full > 19'(port.cap)) ? port.cap : full[13:0];
	end
endmodule // cost_unpack

// ### hw/msgctl_top.sv
// Motion search message control decode with a Wishbone register slave
//
// How it works
// - Cost range bit picks 12 or 10 bits
// - Vector count limit gates partitions, zero skip
// - Early stop below decoded threshold when enabled
// - Early check uses reference 0, source shape
// - Full-pel finish skips sub-pel and intra
// - Transform flag updates only when enabled
// - X-only search for integer and mesh
// - Mix disable forces whole-macroblock bidir decision
// - Skip centre checked before integer search
// - Seven thresholds indexed by row plus column
// - Refine direction uses low bit only
// - Refine subshape two bits per block
// - Refine partition type decoded like output
// - Eight cost points, linear interpolation
// - Chroma penalty zero, one, two times
// - Reference cost base, scaled by mode
// - Ten mode penalties, two-nibble format
// - Signed quarter-pel centres mapped by shape
// - Mesh messages ignore backward centres
// - Fields invalid for message type ignored
`timescale 1ns/1ps
module msgctl_top (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic [1:0]  src_shape,
	input  wire logic        dist_valid,
	input  wire logic        dist_ref_zero,
	input  wire logic [15:0] dist_16x16,
	input  wire logic [15:0] dist_16x8,
	input  wire logic [15:0] dist_8x8,
	input  wire logic        result_valid,
	input  wire logic [7:0]  result_shape,
	input  wire logic [6:0]  mv_dist,
	input  wire logic [3:0]  mode_sel,
	input  wire logic [1:0]  chroma_mode,
	input  wire logic [3:0]  ref_index,
	input  wire logic [1:0]  coef_row,
	input  wire logic [1:0]  coef_col,
	input  wire logic [1:0]  centre_partition_type,
	input  wire logic [1:0]  centre_idx,
	input  wire logic        centre_bwd,
	output logic             search_stop,
	output logic             subpel_skip,
	output logic             intra_skip,
	output logic             skip_check_first,
	output logic             adaptive_search,
	output logic             y_search_off,
	output logic             bidir_per_mb,
	output logic      [3:0]  partition_allow,
	output logic             skip_only,
	output logic             xform_update,
	output logic             large_transform_flag,
	output logic      [11:0] mv_cost,
	output logic      [11:0] mode_penalty,
	output logic      [12:0] chroma_penalty,
	output logic      [15:0] refid_penalty,
	output logic      [15:0] coef_threshold,
	output logic      [15:0] centre_dx,
	output logic      [15:0] centre_dy,
	output logic      [3:0]  refine_backward,
	output logic      [3:0]  refine_minor,
	output logic      [1:0]  refine_partition_type
);

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [msgctl_pkg::NUM_WORDS-1:0][31:0] word;
		logic        ack;
		logic [31:0] rdat;
		logic        early_hit;
		logic        stop;
		logic        subpel_skip;
		logic        intra_skip;
		logic        xform_update;
		logic        large_xform;
		logic [3:0]  allow;
		logic        skip_only;
		logic [3:0]  flags;
		logic [11:0] mv_cost;
		logic [11:0] mode_pen;
		logic [12:0] chroma_pen;
		logic [15:0] refid_pen;
		logic [15:0] coef_thr;
		logic [15:0] centre_dx;
		logic [15:0] centre_dy;
		logic [3:0]  refine_bwd;
		logic [3:0]  refine_minor;
		logic [1:0]  refine_part;
	} state_t;

	state_t s;
	state_t next;

	msgctl_pkg::msg_kind_t kind;
	logic        is_sic;
	logic        is_ime;
	logic        is_fbr;
	logic        is_idm;
	logic [31:0] srch;
	logic        req;
	logic [5:0]  idx;
	logic [31:0] lanes;
	logic        hit_clear;
	logic [31:0] status;

	assign kind   = msgctl_pkg::msg_kind_t'(s.word[msgctl_pkg::W_CTRL][1:0]);
	assign is_sic = kind == msgctl_pkg::skip_intra_check_message;
	assign is_ime = kind == msgctl_pkg::integer_search_message;
	assign is_fbr = kind == msgctl_pkg::fractional_bidir_refine_message;
	assign is_idm = kind == msgctl_pkg::distortion_mesh_message;
	assign srch   = s.word[msgctl_pkg::W_SEARCH];

	// ------------------------------------------------------------------
	// Cost decoders
	// ------------------------------------------------------------------
	logic [msgctl_pkg::NUM_CODES-1:0][7:0]  codes;
	logic [msgctl_pkg::NUM_CODES-1:0][13:0] dec;

	// Modes, reference id, chroma and points sit in consecutive bytes
	assign codes = {srch[31:24], s.word[7], s.word[6], s.word[5],
		s.word[4], s.word[3]};

	cost_if cost [msgctl_pkg::NUM_CODES] ();

	for (genvar i = 0; i < msgctl_pkg::NUM_CODES; i++) begin : g_cost
		assign cost[i].code = codes[i];
		assign cost[i].cap  = msgctl_pkg::cost_cap(i);
		assign dec[i]       = cost[i].value;
		cost_unpack u_unpack (
			.port (cost[i])
		);
	end

	// ------------------------------------------------------------------
	// Search decisions
	// ------------------------------------------------------------------
	logic [15:0] dsel;
	logic        hit;
	logic [5:0]  lim;
	logic        limited;
	logic [3:0]  allow;
	logic [3:0]  flags;
	logic        xform_en;

	// Reference 0 only, distortion picked by source shape
	assign dsel = src_shape == msgctl_pkg::part_8x8 ? dist_8x8 :
		src_shape == msgctl_pkg::part_16x8 ? dist_16x8 : dist_16x16;
	assign hit = dist_valid && dist_ref_zero && is_ime &&
		s.word[msgctl_pkg::W_CTRL][msgctl_pkg::CTRL_EARLY] &&
		dsel < {2'h0, dec[msgctl_pkg::EARLY_CODE]};

	// Vector count limit acts on 16x16 sources in integer search
	assign lim     = s.word[msgctl_pkg::W_LIMIT][5:0];
	assign limited = is_ime && src_shape == msgctl_pkg::part_16x16;
	assign allow   = !limited ? 4'hF : {lim >= 6'h04, lim >= 6'h02,
		lim >= 6'h02, lim != 6'h00};

	// Mode flags other than skip gated by message kind
	assign flags[0] = srch[msgctl_pkg::SRCH_SKIP];
	assign flags[1] = srch[msgctl_pkg::SRCH_ADAPT] && is_ime;
	assign flags[2] = srch[msgctl_pkg::SRCH_XONLY] && (is_ime || is_idm);
	assign flags[3] = srch[msgctl_pkg::SRCH_BIMIX] && is_fbr;
	assign xform_en = srch[msgctl_pkg::SRCH_XFORM] && !is_idm;

	// ------------------------------------------------------------------
	// Refinement inputs, one slice per 8x8 block
	// ------------------------------------------------------------------
	logic [3:0][1:0] dir_code;
	logic [3:0][1:0] shp_code;
	logic [3:0]      ref_bwd;
	logic [3:0]      ref_minor;
	logic [3:0]      dir_bad;

	for (genvar k = 0; k < 4; k++) begin : g_blk
		assign dir_code[k] =
			s.word[msgctl_pkg::W_REFINE][msgctl_pkg::DIR_LSB + 2*k +: 2];
		assign shp_code[k] =
			s.word[msgctl_pkg::W_REFINE][msgctl_pkg::SHAPE_LSB + 2*k +: 2];
		assign ref_bwd[k]   = dir_code[k][0];
		assign ref_minor[k] = shp_code[k] != msgctl_pkg::SHAPE_8X8;
		assign dir_bad[k]   = dir_code[k] == msgctl_pkg::DIR_ILLEGAL;
	end

	// ------------------------------------------------------------------
	// Costs
	// ------------------------------------------------------------------
	logic [2:0]  seg;
	logic [13:0] pt_lo;
	logic [13:0] pt_hi;
	logic [17:0] lerp;
	logic [9:0]  mv_val;
	logic        wide;
	logic        mode_ok;
	logic [11:0] chroma_c;
	logic [12:0] chroma_v;
	logic [11:0] ref_base;
	logic [2:0]  ref_bits;
	logic [3:0]  ref_mult;

	// Points every 16 steps of distance; last segment is flat
	assign seg    = mv_dist[6:4];
	assign pt_lo  = dec[msgctl_pkg::MV_CODE0 + seg];
	assign pt_hi  = seg == 3'h7 ? pt_lo : dec[msgctl_pkg::MV_CODE0 + 1 + seg];
	assign lerp   = 18'(pt_lo[9:0]) * 18'(5'h10 - {1'b0, mv_dist[3:0]}) +
		18'(pt_hi[9:0]) * 18'(mv_dist[3:0]);
	assign mv_val = lerp[13:4];
	assign wide   = s.word[msgctl_pkg::W_LIMIT][msgctl_pkg::LIM_EXT];

	// Mesh messages only carry modes 5 and 8
	assign mode_ok = mode_sel < 4'hA && (!is_idm || mode_sel == 4'h5 ||
		mode_sel == 4'h8);

	// Chroma: DC free, horizontal and vertical once, plane twice
	assign chroma_c = dec[msgctl_pkg::CHROMA_CODE][11:0];
	assign chroma_v = chroma_mode == msgctl_pkg::CHROMA_DC ? 13'h0000 :
		chroma_mode == msgctl_pkg::CHROMA_PLANE ? {chroma_c, 1'b0} :
		{1'b0, chroma_c};

	// Linear mode scales by index, standard mode by index length
	assign ref_base = dec[msgctl_pkg::REFID_CODE][11:0];
	assign ref_bits = ref_index[3] ? 3'h4 : ref_index[2] ? 3'h3 :
		ref_index[1] ? 3'h2 : {2'h0, ref_index[0]};
	assign ref_mult = s.word[msgctl_pkg::W_CTRL][msgctl_pkg::CTRL_LINEAR] ?
		ref_index : {1'b0, ref_bits};

	// ------------------------------------------------------------------
	// Thresholds and cost centres
	// ------------------------------------------------------------------
	logic [2:0]      cidx;
	logic [5:0][7:0] tb;
	logic [15:0]     thr;
	logic [1:0]      cc;
	logic [31:0]     cword;

	assign cidx = {1'b0, coef_row} + {1'b0, coef_col};
	assign tb   = {s.word[msgctl_pkg::W_THR_HI],
		s.word[msgctl_pkg::W_THR_LO][31:16]};
	assign thr  = cidx == 3'h0 ? s.word[msgctl_pkg::W_THR_LO][15:0] :
		{8'h00, tb[cidx - 3'h1]};

	// Shape to centre: second 16x8 uses 2, second 8x16 uses 1
	assign cc = centre_partition_type == msgctl_pkg::part_8x8 ? centre_idx :
		centre_partition_type == msgctl_pkg::part_16x16 ? 2'h0 :
		!centre_idx[0] ? 2'h0 :
		centre_partition_type == msgctl_pkg::part_16x8 ? 2'h2 : 2'h1;
	assign cword = s.word[msgctl_pkg::W_CENTRE + {3'h0, cc, centre_bwd}];

	// ------------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------------
	assign req       = wb_cyc_i && wb_stb_i;
	assign idx       = wb_adr_i[7:2];
	assign lanes     = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
		{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	assign hit_clear = req && s.ack && wb_we_i &&
		idx == msgctl_pkg::W_STATUS && wb_sel_i[0] &&
		wb_dat_i[msgctl_pkg::STAT_HIT];
	assign status    = {26'h0, s.early_hit, |dir_bad, s.flags[3:2],
		s.skip_only, wide};

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb begin
		next      = s;
		next.ack  = req && !s.ack;
		next.rdat = msgctl_pkg::RESET_VALUE;
		if (req && !s.ack) begin
			if (idx == msgctl_pkg::W_STATUS) begin
				next.rdat = status;
			end else if (idx < msgctl_pkg::W_STATUS) begin
				next.rdat = s.word[idx];
			end
		end
		// Writes land at the edge where ack is seen
		for (int w = 0; w < msgctl_pkg::NUM_WORDS; w++) begin
			if (req && s.ack && wb_we_i && idx == 6'(w)) begin
				next.word[w] = (s.word[w] & ~(lanes & msgctl_pkg::write_mask(w)))
					| (wb_dat_i & lanes & msgctl_pkg::write_mask(w));
			end
		end
		next.early_hit   = (s.early_hit && !hit_clear) || hit;
		next.stop        = hit;
		next.subpel_skip = hit && srch[msgctl_pkg::SRCH_FULLPEL];
		next.intra_skip  = hit && srch[msgctl_pkg::SRCH_FULLPEL];
		next.xform_update = result_valid && xform_en;
		if (result_valid && xform_en) begin
			next.large_xform = result_shape == 8'h00;
		end
		next.allow     = allow;
		next.skip_only = limited && lim == 6'h00;
		next.flags     = flags;
		next.mv_cost   = wide ? {mv_val, 2'h0} : {2'h0, mv_val};
		next.mode_pen  = mode_ok ? dec[mode_sel][11:0] : 12'h000;
		next.chroma_pen = is_idm ? 13'h0000 : chroma_v;
		next.refid_pen = 16'(ref_base) * 16'(ref_mult);
		next.coef_thr  = is_sic ? thr : 16'h0000;
		next.centre_dx = (is_idm && centre_bwd) ? 16'h0000 : cword[15:0];
		next.centre_dy = (is_idm && centre_bwd) ? 16'h0000 : cword[31:16];
		next.refine_bwd   = is_fbr ? ref_bwd : 4'h0;
		next.refine_minor = is_fbr ? ref_minor : 4'h0;
		next.refine_part  = is_fbr ?
			s.word[msgctl_pkg::W_REFINE][1:0] : 2'h0;
	end

	// Register the whole state; synchronous reset clears everything
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s <= '0;
		end else begin
			s <= next;
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign wb_dat_o              = s.rdat;
	assign wb_ack_o              = s.ack;
	assign search_stop           = s.stop;
	assign subpel_skip           = s.subpel_skip;
	assign intra_skip            = s.intra_skip;
	assign skip_check_first      = s.flags[0];
	assign adaptive_search       = s.flags[1];
	assign y_search_off          = s.flags[2];
	assign bidir_per_mb          = s.flags[3];
	assign partition_allow       = s.allow;
	assign skip_only             = s.skip_only;
	assign xform_update          = s.xform_update;
	assign large_transform_flag  = s.large_xform;
	assign mv_cost               = s.mv_cost;
	assign mode_penalty          = s.mode_pen;
	assign chroma_penalty        = s.chroma_pen;
	assign refid_penalty         = s.refid_pen;
	assign coef_threshold        = s.coef_thr;
	assign centre_dx             = s.centre_dx;
	assign centre_dy             = s.centre_dy;
	assign refine_backward       = s.refine_bwd;
	assign refine_minor          = s.refine_minor;
	assign refine_partition_type = s.refine_part;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	chk_legacy_range: assert property (
		@(posedge clk) disable iff (!rst_n)
		!wide |=> mv_cost[11:10] == 2'h0)
		else $error("legacy range cost exceeds 10 bits");

	chk_limit_zero: assert property (
		@(posedge clk) disable iff (!rst_n)
		limited && lim == 6'h00 |=> skip_only && partition_allow == 4'h0)
		else $error("zero vector limit did not force skip only");

	chk_early_stop: assert property (
		@(posedge clk) disable iff (!rst_n)
		hit |=> search_stop)
		else $error("early stop missing after hit");

	chk_stop_pulse: assert property (
		@(posedge clk) disable iff (!rst_n)
		!hit |=> !search_stop)
		else $error("early stop raised without hit");

	chk_early_ref: assert property (
		@(posedge clk) disable iff (!rst_n)
		!(dist_valid && dist_ref_zero) |=> !search_stop)
		else $error("early stop without reference 0 distortion");

	chk_fullpel_skip: assert property (
		@(posedge clk) disable iff (!rst_n)
		search_stop |-> subpel_skip == $past(srch[msgctl_pkg::SRCH_FULLPEL])
		&& intra_skip == subpel_skip)
		else $error("sub-pel skip disagrees with full-pel enable");

	chk_xform_hold: assert property (
		@(posedge clk) disable iff (!rst_n)
		!(result_valid && xform_en) |=> $stable(large_transform_flag))
		else $error("transform flag changed while disabled");

	chk_x_only: assert property (
		@(posedge clk) disable iff (!rst_n)
		(is_ime || is_idm) && srch[msgctl_pkg::SRCH_XONLY] |=> y_search_off)
		else $error("x only search not applied");

	chk_bidir_mb: assert property (
		@(posedge clk) disable iff (!rst_n)
		is_fbr && srch[msgctl_pkg::SRCH_BIMIX] |=> bidir_per_mb)
		else $error("whole macroblock bidir decision not applied");

	chk_chroma_plane: assert property (
		@(posedge clk) disable iff (!rst_n)
		chroma_mode == msgctl_pkg::CHROMA_PLANE && !is_idm |=>
		chroma_penalty == {$past(chroma_c), 1'b0})
		else $error("plane chroma penalty not twice the cost");

	chk_mesh_bwd: assert property (
		@(posedge clk) disable iff (!rst_n)
		is_idm && centre_bwd |=> centre_dx == 16'h0000 && centre_dy == 16'h0000)
		else $error("backward centre used for mesh message");

	chk_ack_pulse: assert property (
		@(posedge clk) disable iff (!rst_n)
		wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");

endmodule // msgctl_top

// ### dv/eu_model.sv
// Execution-unit model that issues distortion samples
`timescale 1ns/1ps
module eu_model (
	input  wire logic        clk,
	output logic             dist_valid,
	output logic             dist_ref_zero,
	output logic      [15:0] dist_16x16,
	output logic      [15:0] dist_16x8,
	output logic      [15:0] dist_8x8
);
	initial begin
		dist_valid = 1'b0;
		dist_ref_zero = 1'b0;
		{dist_16x16, dist_16x8, dist_8x8} = '1;
	end
	// One sample for one cycle; other shapes carry a far value
	task automatic send(input logic [15:0] d, input logic r0);
		@(posedge clk);
		dist_valid <= 1'b1;
		dist_ref_zero <= r0;
		dist_16x16 <= d;
		dist_16x8 <= ~d;
		dist_8x8 <= ~d;
		@(posedge clk);
		// Released sample shows junk, not the old value
		dist_valid <= 1'b0;
		dist_16x16 <= ~d;
	endtask
endmodule // eu_model

// ### dv/tb_msgctl_top.sv
// Self-checking bench for the message control block
`timescale 1ns/1ps
module tb_msgctl_top;
	typedef struct packed {
		logic [7:0]  a;
		logic [31:0] w;
		logic [31:0] r;
		logic [3:0]  pa;
	} row_t;
	logic        clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [7:0]  wb_adr_i;
	logic [3:0]  wb_sel_i, partition_allow, refine_backward, refine_minor;
	logic [31:0] wb_dat_i, wb_dat_o, q;
	logic [1:0]  src_shape, chroma_mode, coef_row, coef_col;
	logic [1:0]  centre_partition_type, centre_idx, refine_partition_type;
	logic        centre_bwd, search_stop, subpel_skip, intra_skip;
	logic        skip_check_first, y_search_off, bidir_per_mb, skip_only;
	logic        dist_valid, dist_ref_zero;
	logic [15:0] dist_16x16, dist_16x8, dist_8x8, coef_threshold;
	logic [15:0] centre_dx, centre_dy;
	logic [15:0] th [7];
	logic [12:0] chroma_penalty;
	logic        result_valid, xform_update, large_transform_flag;
	logic        adaptive_search;
	logic [7:0]  result_shape;
	logic [6:0]  mv_dist;
	logic [3:0]  mode_sel, ref_index;
	logic [11:0] mv_cost, mode_penalty;
	logic [15:0] refid_penalty;
	int          fails, n_compared;
	row_t        rows [7];

	msgctl_top dut_u (.clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i,
		.wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .src_shape,
		.dist_valid, .dist_ref_zero, .dist_16x16, .dist_16x8, .dist_8x8,
		.result_valid, .result_shape, .mv_dist,
		.mode_sel, .chroma_mode, .ref_index, .coef_row,
		.coef_col, .centre_partition_type, .centre_idx, .centre_bwd,
		.search_stop, .subpel_skip, .intra_skip, .skip_check_first,
		.adaptive_search, .y_search_off, .bidir_per_mb, .partition_allow,
		.skip_only, .xform_update, .large_transform_flag, .mv_cost,
		.mode_penalty, .chroma_penalty, .refid_penalty, .coef_threshold,
		.centre_dx, .centre_dy, .refine_backward, .refine_minor,
		.refine_partition_type);

	eu_model eu (.clk, .dist_valid, .dist_ref_zero, .dist_16x16,
		.dist_16x8, .dist_8x8);

	// Clock generator
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Compare and count
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	// Classic Wishbone cycle, held until ack is sampled
	task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= 4'hF;
		do @(posedge clk); while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask

	// Let two edges pass so registered outputs settle
	task automatic tick;
		@(posedge clk);
		@(posedge clk);
		#1;
	endtask

	task automatic end_sim;
		$display("Compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Watchdog
	initial begin
		#100000;
		fails++;
		end_sim();
	end

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial begin
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
		{src_shape, chroma_mode, coef_row, coef_col, centre_bwd} = '0;
		{centre_partition_type, centre_idx} = '0;
		{result_valid, result_shape, mv_dist, mode_sel, ref_index} = '0;
		rst_n = 1'b0;
		rows = '{'{8'h00, 32'h9, 32'h9, 4'h0}, '{8'h04, 32'h2, 32'h2, 4'h7},
			'{8'h04, 32'h44, 32'h44, 4'hF},
			'{8'h08, 32'h12000061, 32'h12000061, 4'hF},
			'{8'h20, 32'h00E41B02, 32'h00E41B02, 4'hF},
			'{8'h30, 32'h0004FFF8, 32'h0004FFF8, 4'hF},
			'{8'hFC, 32'h5A5A5A5A, 32'h0, 4'hF}};
		th = '{16'hABCD, 16'h11, 16'h22, 16'h33, 16'h44, 16'h55, 16'h66};
		repeat (19) @(posedge clk);
		#1 chk({wb_ack_o, partition_allow, search_stop, skip_only}, 0);
		@(posedge clk) rst_n <= 1'b1;
		// Register rows: write, read back, partition gating
		foreach (rows[i]) begin
			wb(rows[i].a, 1'b1, rows[i].w);
			wb(rows[i].a, 1'b0, 32'h0);
			chk(q, rows[i].r);
			chk(partition_allow, rows[i].pa);
		end
		chk({y_search_off, skip_check_first, skip_only}, 3'h6);
		// Early stop: strict threshold 4, reference 0, source shape
		eu.send(16'h0003, 1'b1);
		#1 chk({search_stop, subpel_skip, intra_skip}, 3'h7);
		eu.send(16'h0004, 1'b1);
		#1 chk(search_stop, 1'b0);
		eu.send(16'h0003, 1'b0);
		#1 chk(search_stop, 1'b0);
		@(posedge clk) src_shape <= 2'h3;
		eu.send(16'h0003, 1'b1);
		#1 chk({search_stop, partition_allow}, 5'h0F);
		@(posedge clk) src_shape <= 2'h0;
		wb(8'h08, 1'b1, 32'h12000041);
		eu.send(16'h0003, 1'b1);
		#1 chk({search_stop, subpel_skip, intra_skip}, 3'h4);
		// Refinement inputs
		wb(8'h00, 1'b1, 32'h2);
		tick();
		chk({refine_backward, refine_minor, refine_partition_type}, 10'h29E);
		chk(bidir_per_mb, 1'b0);
		wb(8'h20, 1'b1, 32'h00E40002);
		wb(8'h08, 1'b1, 32'h4);
		tick();
		chk(bidir_per_mb, 1'b1);
		// Chroma penalty multiples of code 3
		wb(8'h00, 1'b1, 32'h0);
		wb(8'h14, 1'b1, 32'h03000000);
		for (int m = 0; m < 4; m++) begin
			@(posedge clk) chroma_mode <= 2'(m);
			tick();
			chk(chroma_penalty, (m == 0) ? 0 : (m == 3) ? 6 : 3);
		end
		// Coefficient thresholds indexed by row plus column
		wb(8'h24, 1'b1, 32'h2211ABCD);
		wb(8'h28, 1'b1, 32'h66554433);
		for (int r = 0; r < 4; r++)
			for (int c = 0; c < 4; c++) begin
				@(posedge clk) {coef_row, coef_col} <= {2'(r), 2'(c)};
				tick();
				chk(coef_threshold, th[r + c]);
			end
		// Backward centre: ignored for mesh, raw otherwise
		@(posedge clk) centre_bwd <= 1'b1;
		wb(8'h00, 1'b1, 32'h3);
		tick();
		chk({centre_dx, centre_dy}, 0);
		wb(8'h00, 1'b1, 32'h1);
		tick();
		chk({centre_dx, centre_dy}, 32'hFFF80004);
		// Costs: linear reference scaling, point interpolation, mode 0
		wb(8'h00, 1'b1, 32'h5);
		wb(8'h0C, 1'b1, 32'h21);
		wb(8'h14, 1'b1, 32'h039F0000);
		wb(8'h18, 1'b1, 32'h1404);
		// Adaptive and transform update set, as for a dual start
		wb(8'h08, 1'b1, 32'h82);
		@(posedge clk) {mv_dist, mode_sel, ref_index} <= {7'h08, 8'h0F};
		tick();
		chk({mv_cost, mode_penalty}, 24'h018004);
		chk(refid_penalty, 16'hEFF1);
		chk(adaptive_search, 1'b1);
		// Transform flag follows result shape only while enabled
		@(posedge clk) {result_valid, result_shape} <= 9'h100;
		@(posedge clk) result_valid <= 1'b0;
		#1 chk({xform_update, large_transform_flag}, 2'h3);
		wb(8'h08, 1'b1, 32'h02);
		@(posedge clk) {result_valid, result_shape} <= 9'h155;
		@(posedge clk) result_valid <= 1'b0;
		#1 chk({xform_update, large_transform_flag}, 2'h1);
		// Status word and sticky early hit clear
		wb(8'h4C, 1'b0, 32'h0);
		chk(q, 32'h31);
		wb(8'h4C, 1'b1, 32'h20);
		wb(8'h4C, 1'b0, 32'h0);
		chk(q, 32'h11);
		end_sim();
	end
endmodule // tb_msgctl_top
